// ---- shared/cfgx_pkg.sv ----
// shared constants and carriers for the configuration extension port
package cfgx_pkg;

	// =====================================================================
	// field widths
	localparam int CFGX_REG_W  = 10;
	localparam int CFGX_FUNC_W = 8;
	localparam int CFGX_DATA_W = 32;
	localparam int CFGX_BE_W   = 4;

	// =====================================================================
	// user-implemented register ranges
	localparam logic [CFGX_REG_W-1:0] CFGX_LEG_LO = 10'h010;
	localparam logic [CFGX_REG_W-1:0] CFGX_LEG_HI = 10'h01F;
	localparam logic [CFGX_REG_W-1:0] CFGX_EXT_LO = 10'h100;
	localparam logic [CFGX_REG_W-1:0] CFGX_EXT_HI = 10'h3FF;

	// =====================================================================
	// reset values and user reset timing
	localparam logic [CFGX_DATA_W-1:0] CFGX_DATA_RST = 32'h0000_0000;
	localparam logic [3:0]             CFGX_URST_RST = 4'h0;
	localparam int                     CFGX_CLK_MHZ   = 125;
	localparam int                     CFGX_URST_NS   = 32;
	localparam logic [3:0]             CFGX_URST_CYC  = 4'((CFGX_URST_NS * CFGX_CLK_MHZ + 999) / 1000);

	// =====================================================================
	// sequencer states
	typedef enum logic [1:0] {
		CFGX_IDLE  = 2'b00,
		CFGX_PULSE = 2'b01,
		CFGX_HOLD  = 2'b10
	} cfgx_state_e;

	// request from the link side configuration engine
	typedef struct packed {
		logic                   is_write;
		logic [CFGX_REG_W-1:0]  reg_num;
		logic [CFGX_FUNC_W-1:0] func_num;
		logic [CFGX_DATA_W-1:0] wdata;
		logic [CFGX_BE_W-1:0]   be;
	} cfgx_req_s;

	// indications toward the user application
	typedef struct packed {
		logic                   read_received;
		logic                   write_received;
		logic [CFGX_REG_W-1:0]  reg_num;
		logic [CFGX_FUNC_W-1:0] func_num;
		logic [CFGX_DATA_W-1:0] wdata;
		logic [CFGX_BE_W-1:0]   be;
	} cfgx_user_s;

	// completion back to the link side
	typedef struct packed {
		logic                   valid;
		logic                   from_user;
		logic [CFGX_DATA_W-1:0] data;
	} cfgx_cpl_s;

endpackage

// ---- core/cfgx_port.sv ----
// configuration extension port: link configuration requests to user registers
// =====================================================================
// Behaviour
// RQ1 - with no user space enabled, every read gives a one-cycle read indication
// RQ2 - enabled user range reads hold the read indication until user data is valid
// RQ3 - reads outside both user ranges always give a single-cycle read indication
// RQ4 - each link write gives a single-cycle write indication
// RQ5 - 10-bit register number valid while either indication is high
// RQ6 - 8-bit function number valid while either indication is high
// RQ7 - 32-bit write data valid during the write indication
// RQ8 - 4-bit byte enables accompany every write
// RQ9 - read data sampled on the edge after indication, only when user flags valid
// RQ10 - user returns read data together with its valid strobe
// RQ11 - user must answer every held read, else completion stalls forever
// RQ12 - everything here is synchronous to the single user clock
// RQ13 - user reset output is released synchronously to the user clock
module cfgx_port
	import cfgx_pkg::*;
(
	// clock and reset
	input  wire logic           sys_clk,
	input  wire logic           rst,
	output logic                user_reset,
	// enables for user-implemented space
	input  wire logic           legacy_en,
	input  wire logic           ext_en,
	// link side request
	input  wire logic           req_valid,
	output logic                req_ready,
	input  wire cfgx_pkg::cfgx_req_s req,
	// link side completion
	output cfgx_pkg::cfgx_cpl_s cpl,
	// user application side
	output cfgx_pkg::cfgx_user_s usr,
	input  wire logic [31:0]    usr_read_data,
	input  wire logic           usr_read_data_valid
);
	import cfgx_pkg::*;

	// =====================================================================
	// state
	typedef struct packed {
		cfgx_state_e st;
		cfgx_user_s  usr;
		cfgx_cpl_s   cpl;
		logic [3:0]  urst_cnt;
		logic        urst;
	} cfgx_regs_s;

	cfgx_regs_s s_q;
	cfgx_regs_s s_d;
	logic       user_hit;
	logic       accept;

	// range decode on the incoming register number
	always_comb begin
		user_hit = (legacy_en && req.reg_num >= CFGX_LEG_LO && req.reg_num <= CFGX_LEG_HI) ||
			(ext_en && req.reg_num >= CFGX_EXT_LO && req.reg_num <= CFGX_EXT_HI); // see RQ2 see RQ3
	end

	// only one request in flight; a held read blocks the link (see RQ11)
	assign req_ready = (s_q.st == CFGX_IDLE);
	assign accept    = req_valid && req_ready;

	// =====================================================================
	// next state
	always_comb begin
		s_d               = s_q;
		s_d.cpl.valid     = 1'b0;
		s_d.cpl.from_user = 1'b0;
		// user reset held a few cycles, released on a clock edge
		if (s_q.urst_cnt != CFGX_URST_CYC) begin
			s_d.urst_cnt = s_q.urst_cnt + 4'h1;
		end
		s_d.urst = (s_d.urst_cnt != CFGX_URST_CYC); // see RQ13
		unique case (s_q.st)
			CFGX_IDLE: begin
				if (accept) begin
					// fields captured together with the indication, see RQ5 see RQ6
					s_d.usr.reg_num        = req.reg_num;
					s_d.usr.func_num       = req.func_num;
					s_d.usr.wdata          = req.wdata; // see RQ7
					s_d.usr.be             = req.be; // see RQ8
					s_d.usr.write_received = req.is_write; // see RQ4
					s_d.usr.read_received  = !req.is_write;
					if (!req.is_write && user_hit) begin
						s_d.st = CFGX_HOLD; // see RQ2
					end else begin
						s_d.st = CFGX_PULSE; // see RQ1 see RQ3
					end
				end
			end
			CFGX_PULSE: begin
				// indication lasts one cycle; user data is still taken if offered
				s_d.usr.read_received  = 1'b0;
				s_d.usr.write_received = 1'b0;
				s_d.cpl.valid          = 1'b1;
				if (s_q.usr.read_received && usr_read_data_valid) begin
					s_d.cpl.from_user = 1'b1; // see RQ9
					s_d.cpl.data      = usr_read_data;
				end else begin
					s_d.cpl.data      = CFGX_DATA_RST;
				end
				s_d.st = CFGX_IDLE;
			end
			CFGX_HOLD: begin
				// wait for the user; no timeout, a silent user stalls the read
				if (usr_read_data_valid) begin
					s_d.usr.read_received = 1'b0; // see RQ2
					s_d.cpl.valid         = 1'b1;
					s_d.cpl.from_user     = 1'b1;
					s_d.cpl.data          = usr_read_data; // see RQ9 see RQ10
					s_d.st                = CFGX_IDLE;
				end
			end
			default: begin
				s_d.st = CFGX_IDLE;
			end
		endcase
	end

	// =====================================================================
	// registers, synchronous reset on the single user clock (see RQ12)
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q.st       <= CFGX_IDLE;
			s_q.usr      <= '0;
			s_q.cpl      <= '0;
			s_q.urst_cnt <= CFGX_URST_RST;
			s_q.urst     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign usr        = s_q.usr;
	assign cpl        = s_q.cpl;
	assign user_reset = s_q.urst;

	// =====================================================================
	// checks
	a_single_read_pulse: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
		accept && !req.is_write && !user_hit |=> usr.read_received ##1 !usr.read_received)
		else $error("unheld read indication not one cycle");

	a_write_one_pulse: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
		accept && req.is_write |=> usr.write_received && !usr.read_received ##1 !usr.write_received)
		else $error("write indication not a single pulse");

	a_hold_until_data: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
		s_q.st == CFGX_HOLD && !usr_read_data_valid |=> usr.read_received && $stable(usr.reg_num))
		else $error("held read indication dropped early");

	a_release_on_data: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
		usr.read_received && usr_read_data_valid |=> !usr.read_received && cpl.valid && cpl.from_user
			&& cpl.data == $past(usr_read_data))
		else $error("read data not sampled on valid");

	a_range_hold_enter: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
		accept && !req.is_write && user_hit |=> s_q.st == CFGX_HOLD)
		else $error("user range read not held");

	a_addr_func_capture: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
		accept |=> usr.reg_num == $past(req.reg_num) && usr.func_num == $past(req.func_num))
		else $error("register or function number not presented");

	a_write_data_be: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
		accept && req.is_write |=> usr.wdata == $past(req.wdata) && usr.be == $past(req.be))
		else $error("write data or byte enables wrong");

	a_no_indication_idle: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
		s_q.st == CFGX_IDLE |-> !usr.read_received && !usr.write_received)
		else $error("indication high while idle");

	a_user_reset_release: assert property (@(posedge sys_clk) // see RQ13
		$fell(rst) |-> user_reset [*4] ##1 !user_reset)
		else $error("user reset release timing wrong");

	// =====================================================================
	// decode cross-checks written from the ranges, so a broken user_hit is caught
	a_legacy_hold: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
		accept && !req.is_write && legacy_en && req.reg_num >= CFGX_LEG_LO && req.reg_num <= CFGX_LEG_HI
			|=> s_q.st == CFGX_HOLD)
		else $error("legacy user read not held");

	a_ext_hold: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
		accept && !req.is_write && ext_en && req.reg_num >= CFGX_EXT_LO |=> s_q.st == CFGX_HOLD)
		else $error("extended user read not held");

	a_no_enable_pulse: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
		accept && !req.is_write && !legacy_en && !ext_en |=> s_q.st == CFGX_PULSE)
		else $error("read held with no user space enabled");

	a_out_range_pulse: assert property (@(posedge sys_clk) disable iff (rst) // see RQ3
		accept && !req.is_write && (req.reg_num < CFGX_LEG_LO ||
			(req.reg_num > CFGX_LEG_HI && req.reg_num < CFGX_EXT_LO)) |=> s_q.st == CFGX_PULSE)
		else $error("read outside user ranges held");

	// =====================================================================
	// completion and indication framing
	a_unheld_no_data: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
		s_q.st == CFGX_PULSE && !usr_read_data_valid |=> cpl.valid && !cpl.from_user && cpl.data == CFGX_DATA_RST)
		else $error("user data taken without valid");

	a_cpl_one_cycle: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
		cpl.valid |=> !cpl.valid)
		else $error("completion valid longer than one cycle");

	a_fields_stand: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
		usr.read_received || usr.write_received |=> $stable(usr.reg_num) && $stable(usr.func_num)
			&& $stable(usr.wdata))
		else $error("request fields moved under an indication");

	a_busy_while_ind: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
		usr.read_received || usr.write_received |-> !req_ready)
		else $error("new request possible during an indication");

	a_ind_exclusive: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
		!(usr.read_received && usr.write_received))
		else $error("read and write indication together");

	// user reset follows the core reset at once, release is checked above
	a_user_reset_on: assert property (@(posedge sys_clk) // see RQ13
		rst |=> user_reset)
		else $error("user reset not raised by core reset");

endmodule

// ---- test/cfgx_user_model.sv ----
// behavioural user application answering read indications
module cfgx_user_model
	import cfgx_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 user_reset,
	// indications and reply delay
	input  wire cfgx_pkg::cfgx_user_s usr,
	input  wire logic [1:0]           dly,
	// read reply
	output logic [31:0]               rd_data,
	output logic                      rd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	// ==========
	// reply after dly cycles; bus toggles when not valid so stale data never matches
	always_ff @(posedge sys_clk) begin
		if (user_reset) begin
			rd_valid <= 1'b0;
			cnt_q    <= 2'h0;
			rd_data  <= 32'h0;
		end else if (rd_valid) begin
			rd_valid <= 1'b0;
			cnt_q    <= 2'h0;
			rd_data  <= ~rd_data;
		end else if (usr.read_received && cnt_q == dly) begin
			rd_valid <= 1'b1;
			rd_data  <= {usr.func_num, 14'h0, usr.reg_num} ^ 32'hA5C3_0F00;
		end else begin
			cnt_q   <= usr.read_received ? cnt_q + 2'h1 : 2'h0;
			rd_data <= ~rd_data;
		end
	end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the configuration extension port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cfgx_pkg::*;
	logic        sys_clk = 0, rst = 1, legacy_en = 0, ext_en = 0, req_valid = 0;
	logic        user_reset, req_ready, rd_valid;
	logic [1:0]  dly = 0;
	logic [31:0] rd_data, seed = 27897, v;
	logic [9:0]  corners [8] = '{10'h00F, 10'h010, 10'h01F, 10'h020, 10'h0FF, 10'h100, 10'h3FF, 10'h000};
	cfgx_req_s   req = '0;
	cfgx_user_s  usr;
	cfgx_cpl_s   cpl;
	int          err_count = 0, num_checks = 0, cyc = 0;
	cfgx_port DUT (.sys_clk(sys_clk), .rst(rst), .user_reset(user_reset), .legacy_en(legacy_en),
		.ext_en(ext_en), .req_valid(req_valid), .req_ready(req_ready), .req(req), .cpl(cpl),
		.usr(usr), .usr_read_data(rd_data), .usr_read_data_valid(rd_valid));
	cfgx_user_model u_app (.sys_clk(sys_clk), .user_reset(user_reset), .usr(usr), .dly(dly),
		.rd_data(rd_data), .rd_valid(rd_valid));
	// ==========
	// clock and hang guard
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			complete_run();
		end
	end
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ==========
	// one access; held only for enabled user ranges, so the cpl moment tells them apart
	task access(input logic wr, input logic [9:0] rg);
		logic [31:0] r, w;
		logic        held;
		int          n;
		r = rnd();
		w = rnd();
		held = !wr && ((r[12] && rg >= CFGX_LEG_LO && rg <= CFGX_LEG_HI) || (r[13] && rg >= CFGX_EXT_LO));
		@(posedge sys_clk);
		req_valid <= 1;
		req <= '{is_write: wr, reg_num: rg, func_num: r[7:0], wdata: w, be: r[11:8]};
		legacy_en <= r[12];
		ext_en <= r[13];
		dly <= r[15:14];
		@(posedge sys_clk);
		req_valid <= 0;
		#1;
		chk("busy", 0, req_ready);
		chk("reg_num", rg, usr.reg_num);
		chk("func_num", r[7:0], usr.func_num);
		chk("read_received", !wr, usr.read_received);
		chk("write_received", wr, usr.write_received);
		if (wr) begin
			chk("wdata", w, usr.wdata);
			chk("be", r[11:8], usr.be);
		end
		for (n = 1; n < 12 && cpl.valid !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
			if (cpl.valid !== 1'b1) begin
				chk("held", 1, usr.read_received);
				chk("held busy", 0, req_ready);
			end
		end
		chk("cpl moment", held ? r[15:14] + 3 : 2, n);
		chk("ind drop", 0, usr.read_received | usr.write_received);
		chk("from_user", held, cpl.from_user);
		chk("ready back", 1, req_ready);
		chk("cpl data", held ? {r[7:0], 14'h0, rg} ^ 32'hA5C3_0F00 : 0, cpl.data);
	endtask
	// ==========
	// reset for len-1 edges; user reset drops on the fourth edge after release
	task reset_seq(input int len);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (len - 1) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("rst ready", 1, req_ready);
		chk("rst cpl", 0, cpl.valid);
		chk("rst ind", 0, usr.read_received | usr.write_received);
		repeat (3) begin
			@(posedge sys_clk);
			#1;
			chk("user_reset hold", 1, user_reset);
		end
		@(posedge sys_clk);
		#1;
		chk("user_reset free", 0, user_reset);
	endtask
	// reset, corner registers both ways, a mid-run reset, then random traffic
	initial begin
		reset_seq(16);
		$display("reset test done");
		foreach (corners[i]) begin
			access(1'b0, corners[i]);
			access(1'b1, corners[i]);
		end
		$display("corner test done");
		reset_seq(4);
		$display("mid reset test done");
		repeat (300) begin
			v = rnd();
			access(v[0], v[10:1]);
		end
		$display("random test done");
		complete_run();
	end
endmodule
